// file: rtl/bsc_pkg.sv
`default_nettype none

package bsc_pkg;

    // register port geometry
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam int PORT_STRIDE = 128;

    // byte offsets inside one port window
    localparam logic [8:0] OFF_STATUS_LIVE    = 9'h05C;
    localparam logic [8:0] OFF_STATUS_LATCHED = 9'h05E;
    localparam logic [8:0] OFF_IRQ_ENABLE     = 9'h060;
    localparam logic [8:0] OFF_ERR_LOW        = 9'h064;
    localparam logic [8:0] OFF_ERR_HIGH       = 9'h066;
    localparam logic [8:0] OFF_BITS_LOW       = 9'h068;
    localparam logic [8:0] OFF_BITS_HIGH      = 9'h06A;

    // flag positions, shared by live, latched and enable registers
    localparam int FLAG_W      = 4;
    localparam int BIT_UPDATE  = 3;
    localparam int BIT_BITERR  = 2;
    localparam int BIT_NONZERO = 1;
    localparam int BIT_SYNC    = 0;

    // counter widths and holding-word split
    localparam int ERR_W  = 24;
    localparam int BITS_W = 32;
    localparam int HALF_W = 16;
    localparam int ERR_HIGH_W = 8;

    // reset values
    localparam logic [FLAG_W-1:0] FLAGS_RESET   = 4'h0;
    localparam logic [FLAG_W-1:0] IRQEN_RESET   = 4'h0;
    localparam logic [ERR_W-1:0]  ERR_RESET     = 24'h000000;
    localparam logic [BITS_W-1:0] BITS_RESET    = 32'h00000000;
    localparam logic [DATA_W-1:0] RDATA_RESET   = 16'h0000;

endpackage

`default_nettype wire

// file: rtl/bsc_sat_counter.sv
`default_nettype none

module bsc_sat_counter #(
    parameter int WIDTH = 24
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             clear,
    input  wire logic             inc,
    output logic [WIDTH-1:0]      count
);

    logic             all_ones;
    logic [WIDTH-1:0] next_count;

    assign all_ones = &count;

    // a clear that meets an increment starts the new interval at one
    always_comb
    begin
        next_count = count;
        if (clear)
        begin
            next_count = inc ? WIDTH'(1) : '0;
        end
        else if (inc && !all_ones)
        begin
            next_count = count + WIDTH'(1);
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            count <= '0;
        else
            count <= next_count;
    end

endmodule

`default_nettype wire

// file: rtl/bsc_top.sv
`default_nettype none

module bsc_top #(
    parameter int PORT_INDEX = 0
) (
    input  wire logic                         clock,
    input  wire logic                         rst,
    input  wire logic [bsc_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [bsc_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                         reg_write,
    input  wire logic                         reg_read,
    output logic      [bsc_pkg::DATA_W-1:0]   reg_rdata,
    output logic                              reg_ack,
    input  wire logic                         local_update_request,
    input  wire logic                         update_source_select,
    input  wire logic                         remote_update_request,
    input  wire logic                         port_tester_irq_en,
    input  wire logic                         global_port_irq_en,
    input  wire logic                         rx_bit_valid,
    input  wire logic                         rx_bit_error,
    input  wire logic                         out_of_sync,
    output logic                              update_done,
    output logic                              irq
);

    localparam logic [bsc_pkg::ADDR_W-1:0] PORT_BASE =
        bsc_pkg::ADDR_W'(PORT_INDEX * bsc_pkg::PORT_STRIDE);

    // one address comparator per register, all built the same way
    function automatic logic bsc_hit(
        input logic [bsc_pkg::ADDR_W-1:0] addr,
        input logic [bsc_pkg::ADDR_W-1:0] offset
    );
        bsc_hit = (addr == (PORT_BASE + offset));
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic                          sel_req_prev;
    logic                          hold_loaded;
    logic                          update_done_prev;
    logic                          oos_live;
    logic                          oos_prev;
    logic                          nonzero_prev;
    logic [bsc_pkg::FLAG_W-1:0]    flags;
    logic [bsc_pkg::FLAG_W-1:0]    irq_en;
    logic [bsc_pkg::ERR_W-1:0]     err_hold;
    logic [bsc_pkg::BITS_W-1:0]    bits_hold;
    logic [bsc_pkg::ERR_W-1:0]     err_count;
    logic [bsc_pkg::BITS_W-1:0]    bits_count;

    // ------------------------------------------------------------------
    // update request selection and edge
    // ------------------------------------------------------------------
    logic sel_req;
    logic update_pulse;
    logic next_update_done;

    assign sel_req = update_source_select ? remote_update_request : local_update_request;
    // a rising request starts an update; flipping the selector can also do it
    assign update_pulse = sel_req && !sel_req_prev;
    // low request forces zero; set only after the load cycle finished
    assign next_update_done = sel_req && (update_done || hold_loaded);

    // ------------------------------------------------------------------
    // counters
    // ------------------------------------------------------------------
    logic count_en;
    logic err_inc;
    logic bits_inc;

    // no counting while the checker has lost the pattern
    assign count_en = !out_of_sync;
    assign err_inc  = count_en && rx_bit_error;
    assign bits_inc = count_en && rx_bit_valid;

    bsc_sat_counter #(
        .WIDTH (bsc_pkg::ERR_W)
    ) u_err_counter (
        .clock (clock),
        .rst   (rst),
        .clear (update_pulse),
        .inc   (err_inc),
        .count (err_count)
    );

    bsc_sat_counter #(
        .WIDTH (bsc_pkg::BITS_W)
    ) u_bits_counter (
        .clock (clock),
        .rst   (rst),
        .clear (update_pulse),
        .inc   (bits_inc),
        .count (bits_count)
    );

    // ------------------------------------------------------------------
    // live status and event detection
    // ------------------------------------------------------------------
    logic                        nonzero_live;
    logic                        ev_update_rise;
    logic                        ev_nonzero_rise;
    logic                        ev_sync_change;
    logic                        ev_restart_one;
    logic [bsc_pkg::FLAG_W-1:0]  live_status;
    logic [bsc_pkg::FLAG_W-1:0]  set_events;

    // nonzero follows the running error counter
    assign nonzero_live = |err_count;
    // only the zero-to-one edge of update-done counts
    assign ev_update_rise = update_done && !update_done_prev;
    assign ev_nonzero_rise = nonzero_live && !nonzero_prev;
    // clear met by an error leaves the count at one with no visible edge
    assign ev_restart_one = update_pulse && err_inc;
    // both loss and regain of sync
    assign ev_sync_change = oos_live != oos_prev;

    always_comb
    begin
        live_status = bsc_pkg::FLAGS_RESET;
        live_status[bsc_pkg::BIT_UPDATE]  = update_done;
        live_status[bsc_pkg::BIT_NONZERO] = nonzero_live;
        live_status[bsc_pkg::BIT_SYNC]    = oos_live;
    end

    always_comb
    begin
        set_events = bsc_pkg::FLAGS_RESET;
        set_events[bsc_pkg::BIT_UPDATE]  = ev_update_rise;
        // every checker error, counted or not
        set_events[bsc_pkg::BIT_BITERR]  = rx_bit_error;
        set_events[bsc_pkg::BIT_NONZERO] = ev_nonzero_rise || ev_restart_one;
        set_events[bsc_pkg::BIT_SYNC]    = ev_sync_change;
    end

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    logic hit_live;
    logic hit_latched;
    logic hit_irq_en;
    logic hit_err_low;
    logic hit_err_high;
    logic hit_bits_low;
    logic hit_bits_high;
    logic hit_any;
    logic wr_latched;
    logic wr_irq_en;

    assign hit_live      = bsc_hit(reg_addr, bsc_pkg::OFF_STATUS_LIVE);
    assign hit_latched   = bsc_hit(reg_addr, bsc_pkg::OFF_STATUS_LATCHED);
    assign hit_irq_en    = bsc_hit(reg_addr, bsc_pkg::OFF_IRQ_ENABLE);
    assign hit_err_low   = bsc_hit(reg_addr, bsc_pkg::OFF_ERR_LOW);
    assign hit_err_high  = bsc_hit(reg_addr, bsc_pkg::OFF_ERR_HIGH);
    assign hit_bits_low  = bsc_hit(reg_addr, bsc_pkg::OFF_BITS_LOW);
    assign hit_bits_high = bsc_hit(reg_addr, bsc_pkg::OFF_BITS_HIGH);
    assign hit_any = hit_live || hit_latched || hit_irq_en || hit_err_low
                   || hit_err_high || hit_bits_low || hit_bits_high;
    assign wr_latched = reg_write && hit_latched;
    assign wr_irq_en  = reg_write && hit_irq_en;

    // ------------------------------------------------------------------
    // latched flags and enables
    // ------------------------------------------------------------------
    logic [bsc_pkg::FLAG_W-1:0] clear_mask;
    logic [bsc_pkg::FLAG_W-1:0] next_flags;

    // write one clears; a set in the same cycle wins
    assign clear_mask = wr_latched ? reg_wdata[bsc_pkg::FLAG_W-1:0] : bsc_pkg::FLAGS_RESET;
    assign next_flags = (flags & ~clear_mask) | set_events;

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    logic [bsc_pkg::DATA_W-1:0] read_value;
    logic [bsc_pkg::DATA_W-1:0] err_high_word;

    // top byte of the upper error word reads zero
    assign err_high_word = {{(bsc_pkg::DATA_W - bsc_pkg::ERR_HIGH_W){1'b0}},
                            err_hold[bsc_pkg::ERR_W-1:bsc_pkg::HALF_W]};

    always_comb
    begin
        read_value = bsc_pkg::RDATA_RESET;
        if (hit_live)
            read_value[bsc_pkg::FLAG_W-1:0] = live_status;
        else if (hit_latched)
            read_value[bsc_pkg::FLAG_W-1:0] = flags;
        else if (hit_irq_en)
            read_value[bsc_pkg::FLAG_W-1:0] = irq_en;
        else if (hit_err_low)
            read_value = err_hold[bsc_pkg::HALF_W-1:0];
        else if (hit_err_high)
            read_value = err_high_word;
        // bit count as two full words
        else if (hit_bits_low)
            read_value = bits_hold[bsc_pkg::HALF_W-1:0];
        else if (hit_bits_high)
            read_value = bits_hold[bsc_pkg::BITS_W-1:bsc_pkg::HALF_W];
    end

    // ------------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------------
    logic next_irq;

    // flag enable, port enable and global enable all needed
    // enable bits share the flag positions
    assign next_irq = (|(flags & irq_en)) && port_tester_irq_en && global_port_irq_en;

    // ------------------------------------------------------------------
    // processes
    // ------------------------------------------------------------------

    // update handshake tracking
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sel_req_prev <= 1'b0;
            hold_loaded  <= 1'b0;
            update_done  <= 1'b0;
        end
        else
        begin
            sel_req_prev <= sel_req;
            // both holding words are written in the update cycle
            hold_loaded  <= update_pulse;
            update_done  <= next_update_done;
        end
    end

    // holding registers change only on an update
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            err_hold  <= bsc_pkg::ERR_RESET;
            bits_hold <= bsc_pkg::BITS_RESET;
        end
        else if (update_pulse)
        begin
            err_hold  <= err_count;
            bits_hold <= bits_count;
        end
    end

    // one register stage so every edge is seen exactly once
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            oos_live         <= 1'b0;
            oos_prev         <= 1'b0;
            nonzero_prev     <= 1'b0;
            update_done_prev <= 1'b0;
        end
        else
        begin
            oos_live         <= out_of_sync;
            oos_prev         <= oos_live;
            nonzero_prev     <= nonzero_live;
            update_done_prev <= update_done;
        end
    end

    // latched flags and enable register
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            flags  <= bsc_pkg::FLAGS_RESET;
            irq_en <= bsc_pkg::IRQEN_RESET;
        end
        else
        begin
            flags <= next_flags;
            if (wr_irq_en)
                irq_en <= reg_wdata[bsc_pkg::FLAG_W-1:0];
        end
    end

    // registered read data; unmapped reads give zero and no ack
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= bsc_pkg::RDATA_RESET;
            reg_ack   <= 1'b0;
            irq       <= 1'b0;
        end
        else
        begin
            reg_rdata <= reg_read ? read_value : bsc_pkg::RDATA_RESET;
            reg_ack   <= (reg_read || reg_write) && hit_any;
            irq       <= next_irq;
        end
    end

endmodule

`default_nettype wire

// file: sim/bsc_status_monitor.sv
`default_nettype none

module bsc_status_monitor #(
    parameter int PORT_INDEX = 0
) (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [8:0]  reg_addr,
    input wire logic        reg_read,
    input wire logic        reg_write,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_ack,
    input wire logic        local_update_request,
    input wire logic        update_source_select,
    input wire logic        remote_update_request,
    input wire logic        port_tester_irq_en,
    input wire logic        global_port_irq_en,
    input wire logic        update_done,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [8:0] BASE = 9'(PORT_INDEX * 128);

    // request as the block selects it, and any bus strobe
    wire logic sel_req = update_source_select ? remote_update_request : local_update_request;
    wire logic strobe = reg_read | reg_write;

    default clocking mon_cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_window_ack: assert property (strobe && reg_addr == BASE + 9'h060 |=> reg_ack)
        else $error("mapped access not acked");
    a_foreign_noack: assert property (strobe && reg_addr[8:7] != 2'(PORT_INDEX)
        |=> !reg_ack && reg_rdata == 16'h0000)
        else $error("foreign address answered");
    a_ack_cause: assert property (reg_ack |-> $past(strobe))
        else $error("ack without strobe");
    a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
        else $error("read data outside a read");
    a_done_drops: assert property (!sel_req |=> !update_done)
        else $error("update done stays high");
    a_done_timing: assert property ($rose(sel_req) ##1 sel_req |=> update_done)
        else $error("update done late");
    a_done_early: assert property ($rose(sel_req) |-> !update_done ##1 !update_done)
        else $error("update done early");
    a_irq_enables: assert property (irq |-> $past(port_tester_irq_en)
        && $past(global_port_irq_en))
        else $error("irq while disabled");
endmodule

bind bsc_top bsc_status_monitor #(.PORT_INDEX(PORT_INDEX)) u_bsc_status_monitor (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_read(reg_read),
    .reg_write(reg_write), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .local_update_request(local_update_request), .update_source_select(update_source_select),
    .remote_update_request(remote_update_request), .port_tester_irq_en(port_tester_irq_en),
    .global_port_irq_en(global_port_irq_en), .update_done(update_done), .irq(irq)
);

`default_nettype wire

// file: sim/bsc_top_tb.sv
`default_nettype none

module bsc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [8:0] BASE = 9'h080;
    logic        clock = 1'h0, rst = 1'h1, reg_write = 1'h0, reg_read = 1'h0, reg_ack;
    logic [8:0]  reg_addr = 9'h000;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd;
    logic        local_update_request = 1'h0, update_source_select = 1'h0;
    logic        remote_update_request = 1'h0, port_tester_irq_en = 1'h0;
    logic        global_port_irq_en = 1'h0, rx_bit_valid = 1'h0, rx_bit_error = 1'h0;
    logic        out_of_sync = 1'h0, update_done, irq;
    int          fails = 0, check_count = 0;

    // second port window, so the base offset is exercised
    bsc_top #(.PORT_INDEX(1)) u_bsc_top (.clock, .rst, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .reg_ack, .local_update_request, .update_source_select,
        .remote_update_request, .port_tester_irq_en, .global_port_irq_en, .rx_bit_valid,
        .rx_bit_error, .out_of_sync, .update_done, .irq);

    // free running clock
    initial
    begin
        forever #4 clock = ~clock;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask

    // one strobe cycle, answer looked at in the cycle after; a quiet cycle
    // follows so the next access never re-raises a strobe in the same step
    task automatic acc(input logic wr, input logic [8:0] a, input logic [15:0] wd,
                       input logic ack);
        reg_addr = a;
        reg_wdata = wd;
        reg_write = wr;
        reg_read = !wr;
        idle(1);
        check("reg_ack", ack, reg_ack);
        rd = reg_rdata;
        reg_write = 1'h0;
        reg_read = 1'h0;
        idle(1);
    endtask

    task automatic wr(input logic [8:0] off, input logic [15:0] wd);
        acc(1'h1, BASE + off, wd, 1'h1);
    endtask

    task automatic rd_chk(input string name, input logic [8:0] off, input logic [15:0] exp);
        acc(1'h0, BASE + off, 16'h0000, 1'h1);
        check(name, exp, rd);
    endtask

    // back to back received bits
    task automatic send(input int n, input logic err);
        repeat (n)
        begin
            rx_bit_valid = 1'h1;
            rx_bit_error = err;
            idle(1);
        end
        rx_bit_valid = 1'h0;
        rx_bit_error = 1'h0;
        idle(3);
    endtask

    // request held until done, optional bit on the update edge
    task automatic pm_update(input logic remote, input logic pulse);
        int n;
        n = 0;
        update_source_select = remote;
        local_update_request = !remote;
        remote_update_request = remote;
        rx_bit_valid = pulse;
        rx_bit_error = pulse;
        while (update_done !== 1'h1 && n < 8)
        begin
            idle(1);
            rx_bit_valid = 1'h0;
            rx_bit_error = 1'h0;
            n++;
        end
        check("update latency", 2, n);
        local_update_request = 1'h0;
        remote_update_request = 1'h0;
        idle(3);
        check("update_done", 1'h0, update_done);
    endtask

    task automatic t_reset_map();
        for (int i = 0; i < 7; i++)
            rd_chk("reset value", 9'h05C + 9'(i < 3 ? 2 * i : 2 * i + 2), 16'h0000);
        acc(1'h0, 9'h05E, 16'h0000, 1'h0);
        check("foreign rdata", 16'h0000, rd);
        acc(1'h0, BASE + 9'h062, 16'h0000, 1'h0);
        wr(9'h060, 16'hFFFF);
        rd_chk("irq enable", 9'h060, 16'h000F);
        wr(9'h064, 16'h1234);
        rd_chk("read only word", 9'h064, 16'h0000);
        wr(9'h060, 16'h0000);
    endtask

    task automatic t_count();
        send(2, 1'h0);
        rd_chk("latched clean", 9'h05E, 16'h0000);
        send(3, 1'h1);
        rd_chk("live nonzero", 9'h05C, 16'h0002);
        wr(9'h05E, 16'h0000);
        rd_chk("latched errors", 9'h05E, 16'h0006);
        pm_update(1'h0, 1'h0);
        rd_chk("error low", 9'h064, 16'h0003);
        rd_chk("error high", 9'h066, 16'h0000);
        rd_chk("bits low", 9'h068, 16'h0005);
        rd_chk("bits high", 9'h06A, 16'h0000);
        rd_chk("live cleared", 9'h05C, 16'h0000);
        rd_chk("latched update", 9'h05E, 16'h000E);
        wr(9'h05E, 16'h000F);
        rd_chk("latched cleared", 9'h05E, 16'h0000);
    endtask

    task automatic t_sync();
        out_of_sync = 1'h1;
        idle(3);
        rd_chk("live sync", 9'h05C, 16'h0001);
        send(4, 1'h1);
        rd_chk("latched loss", 9'h05E, 16'h0005);
        wr(9'h05E, 16'h000F);
        out_of_sync = 1'h0;
        idle(3);
        rd_chk("latched regain", 9'h05E, 16'h0001);
        pm_update(1'h0, 1'h0);
        rd_chk("frozen errors", 9'h064, 16'h0000);
        rd_chk("frozen bits", 9'h068, 16'h0000);
        wr(9'h05E, 16'h000F);
    endtask

    task automatic t_irq();
        wr(9'h060, 16'h0004);
        port_tester_irq_en = 1'h1;
        send(1, 1'h1);
        check("irq global off", 1'h0, irq);
        global_port_irq_en = 1'h1;
        idle(2);
        check("irq on", 1'h1, irq);
        port_tester_irq_en = 1'h0;
        idle(2);
        check("irq port off", 1'h0, irq);
        port_tester_irq_en = 1'h1;
        wr(9'h060, 16'h0009);
        idle(2);
        check("irq masked", 1'h0, irq);
        wr(9'h05E, 16'h000F);
        wr(9'h060, 16'h0000);
    endtask

    task automatic t_remote();
        pm_update(1'h1, 1'h1);
        rd_chk("latched restart", 9'h05E, 16'h000E);
        rd_chk("error before", 9'h064, 16'h0001);
        rd_chk("bits before", 9'h068, 16'h0001);
        wr(9'h05E, 16'h000F);
        pm_update(1'h1, 1'h0);
        rd_chk("error restart", 9'h064, 16'h0001);
        rd_chk("bits restart", 9'h068, 16'h0001);
    endtask

    // local update met by a counted bit restarts both counters at one;
    // full-width saturation is out of reach in a bench of this length
    task automatic t_restart();
        pm_update(1'h0, 1'h1);
        pm_update(1'h0, 1'h0);
        rd_chk("restart error", 9'h064, 16'h0001);
        rd_chk("restart bits", 9'h068, 16'h0001);
        pm_update(1'h0, 1'h0);
        rd_chk("cleared error", 9'h064, 16'h0000);
    endtask

    // hang guard
    initial
    begin
        repeat (5000) @(posedge clock);
        fails++;
        $display("ERROR run length expected end seen timeout");
        conclude();
    end

    initial
    begin
        idle(20);
        rst = 1'h0;
        idle(1);
        t_reset_map();
        t_count();
        t_sync();
        t_irq();
        t_remote();
        t_restart();
        conclude();
    end
endmodule

`default_nettype wire
